// [core/drive_ctrl.sv]
// Purpose: Format, spin-up and read cache decisions of a serial disk drive
// Assumes: APB register access, single 100 MHz clock
// Notes: Long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
`include "drive_ctrl_map.svh"

// Behaviour
// RQ1: Fast-format field value 01b selects quick format instead of full format.
// RQ2: Field 10b or 11b rejects with 05/24, pointing at field MSB.
// RQ3: New sector size stays pending until a format completes.
// RQ4: Fast conversion only when sizes differ by exact factor eight.
// RQ5: Reset starts in 512-byte emulated mode.
// RQ6: Host sends block descriptor then mode select to change size.
// RQ7: Host sends immediate header and format command for fast format.
// RQ8: Commands accepted within three seconds of power-on.
// RQ9: Enable-spinup without prior stop gives ready within thirty seconds.
// RQ10: Stop first: wait start, then enable-spinup, then ready in thirty seconds.
// RQ11: Start with immediate fails if no enable-spinup within five seconds.
// RQ12: Stop without immediate returns status only after stop completes.
// RQ13: Each segment records which block addresses it holds.
// RQ14: Read caching on: look in the buffer before medium access.
// RQ15: Read caching off: skip lookup, read the medium directly.
// RQ16: Full hit transfers blocks with no medium access.
// RQ17: Any miss fetches from medium into a segment, then forwards.
// RQ18: Segments are independent rings, created and removed by workload.
// RQ19: Segment-size field always reads back as 0xffff.
// RQ20: Written segment-size value is ignored.
// RQ21: Check_bit_a bit set makes a segment-size change an error.
// RQ22: Prefetch and caching are enabled independently.
// RQ23: Read-cache-disable 0 enables caching, 1 disables it.
// RQ24: Disable-read-ahead 0 enables prefetch; the bit is only stored, no prefetch logic reads it.
// RQ25: Reset leaves spin-up not ready, no stop recorded.
module drive_ctrl
   import drive_ctrl_pkg::*;
#(
   parameter int ACCEPT_CYC = `MS_TO_CYC(`CMD_ACCEPT_MS),
   parameter int READY_CYC = `MS_TO_CYC(`READY_WAIT_MS),
   parameter int FAIL_CYC = `MS_TO_CYC(`SPINUP_FAIL_MS),
   parameter int SEGS = 4,
   parameter int LBA_W = 32,
   parameter int LEN_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enable_spinup_a,
   input wire logic enable_spinup_b,
   input wire logic format_done,
   input wire logic spindle_stopped,
   output logic spindle_on,
   output logic medium_read,
   output logic buffer_xfer
);
   import drive_ctrl_pkg::*;

   if (SEGS < 1 || SEGS > 16 || LEN_W < 1 || LEN_W > 31 || LEN_W > LBA_W || READY_CYC < 1
       || FAIL_CYC < 1 || ACCEPT_CYC < 1) begin : g_bad_param
      $error("drive_ctrl: unsupported parameters");
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0] s1_r, s2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= {spindle_stopped, format_done, enable_spinup_b, enable_spinup_a};
         s2_r <= s1_r;
      end
   end
   logic en_spin, fmt_done_lvl, stopped_lvl;
   logic fmt_prev_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_prev_r <= 1'b0;
      end else begin
         fmt_prev_r <= fmt_done_lvl;
      end
   end
   assign en_spin = s2_r[0] | s2_r[1];
   assign fmt_done_lvl = s2_r[2];
   assign stopped_lvl = s2_r[3];
   logic fmt_done_p;
   assign fmt_done_p = fmt_done_lvl & ~fmt_prev_r;

   // ****************************************
   // APB decode
   // ****************************************
   logic wr, rd;
   assign pready = 1'b1;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;

   // ****************************************
   // Power-on acceptance timer
   // ****************************************
   logic [31:0] acc_cnt_r, acc_cnt_nxt;
   logic accept_r, accept_nxt;
   always_comb begin
      acc_cnt_nxt = acc_cnt_r;
      accept_nxt = accept_r;
      if (!accept_r) begin
         acc_cnt_nxt = acc_cnt_r + 32'h1;
         if (acc_cnt_r == 32'(ACCEPT_CYC - 1)) begin
            accept_nxt = 1'b1; // RQ8
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_cnt_r <= '0;
         accept_r <= 1'b0;
      end else begin
         acc_cnt_r <= acc_cnt_nxt;
         accept_r <= accept_nxt;
      end
   end

   // ****************************************
   // Command register fields
   // ****************************************
   // CMD write: [0] start_unit, [1] start bit, [2] immediate_return_bit,
   // [3] format, [5:4] fast_format_field, [6] format_data_present,
   // [8] select sector size, [9] size code (0 small emulated, 1 native large),
   // [10] save_pages_bit
   logic cmd_wr;
   assign cmd_wr = wr && paddr == `OFF_CMD && accept_r;
   logic c_start_unit, c_start, c_imm, c_fmt, c_format_data_present, c_sel, c_size, c_save;
   logic [1:0] fast_format_field;
   assign c_start_unit = pwdata[0];
   assign c_start = pwdata[1];
   assign c_imm = pwdata[2];
   assign c_fmt = pwdata[3];
   assign fast_format_field = pwdata[5:4];
   assign c_format_data_present = pwdata[6];
   assign c_sel = pwdata[8];
   assign c_size = pwdata[9];
   assign c_save = pwdata[10];

   // ****************************************
   // Format and sector size
   // ****************************************
   sector_mode_e mode_r, mode_nxt, pend_r, pend_nxt;
   logic fmt_busy_r, fmt_busy_nxt, quick_r, quick_nxt;
   logic check_r, check_nxt;
   logic [7:0] sense_key_r, sense_key_nxt, sense_code_r, sense_code_nxt;
   logic [7:0] field_ptr_r, field_ptr_nxt;
   logic ratio_ok;
   // Both sizes known: 512 and 4096, ratio eight
   assign ratio_ok = (4096 / 512) == `SECTOR_RATIO;
   always_comb begin
      mode_nxt = mode_r;
      pend_nxt = pend_r;
      fmt_busy_nxt = fmt_busy_r;
      quick_nxt = quick_r;
      check_nxt = check_r;
      sense_key_nxt = sense_key_r;
      sense_code_nxt = sense_code_r;
      field_ptr_nxt = field_ptr_r;
      if (cmd_wr && c_sel && c_save) begin
         pend_nxt = c_size ? MODE_NATIVE_LARGE : MODE_EMU_SMALL; // RQ3
      end
      if (cmd_wr && c_fmt && !fmt_busy_r) begin
         if (fast_format_field[1]) begin
            check_nxt = 1'b1; // RQ2
            sense_key_nxt = `SENSE_KEY_ILLEGAL;
            sense_code_nxt = `SENSE_CODE_INVALID;
            field_ptr_nxt = 8'h41; // Byte 4, bit 1
         end else begin
            fmt_busy_nxt = 1'b1;
            // Quick only for exact factor eight, else full
            quick_nxt = (fast_format_field == `FF_QUICK) && c_format_data_present && ratio_ok; // RQ1 RQ4
         end
      end
      if (fmt_busy_r && fmt_done_p) begin
         fmt_busy_nxt = 1'b0;
         mode_nxt = pend_r; // RQ3
      end
      if (rd && paddr == `OFF_SENSE) begin
         check_nxt = 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= MODE_EMU_SMALL; // RQ5
         pend_r <= MODE_EMU_SMALL;
         fmt_busy_r <= 1'b0;
         quick_r <= 1'b0;
         check_r <= 1'b0;
         sense_key_r <= '0;
         sense_code_r <= '0;
         field_ptr_r <= '0;
      end else begin
         mode_r <= mode_nxt;
         pend_r <= pend_nxt;
         fmt_busy_r <= fmt_busy_nxt;
         quick_r <= quick_nxt;
         check_r <= check_nxt;
         sense_key_r <= sense_key_nxt;
         sense_code_r <= sense_code_nxt;
         field_ptr_r <= field_ptr_nxt;
      end
   end

   // ****************************************
   // Spin-up sequencer
   // ****************************************
   spin_state_e sp_r, sp_nxt;
   logic [31:0] sp_cnt_r, sp_cnt_nxt;
   logic start_fail_r, start_fail_nxt, imm_wait_r, imm_wait_nxt;
   logic stop_done_r, stop_done_nxt;
   always_comb begin
      sp_nxt = sp_r;
      sp_cnt_nxt = sp_cnt_r;
      start_fail_nxt = start_fail_r;
      imm_wait_nxt = imm_wait_r;
      stop_done_nxt = stop_done_r;
      if (imm_wait_r) begin
         sp_cnt_nxt = sp_cnt_r + 32'h1;
      end
      case (sp_r)
         SP_IDLE: begin
            if (cmd_wr && c_start_unit && !c_start) begin
               sp_nxt = SP_WAIT_START; // RQ10
            end else if (en_spin) begin
               sp_nxt = SP_SPIN; // RQ9
               sp_cnt_nxt = '0;
            end
         end
         SP_WAIT_START: begin
            if (cmd_wr && c_start_unit && c_start) begin
               sp_nxt = SP_WAIT_EN; // RQ10
               imm_wait_nxt = c_imm;
               start_fail_nxt = 1'b0;
               sp_cnt_nxt = '0;
            end
         end
         SP_WAIT_EN: begin
            if (en_spin) begin
               sp_nxt = SP_SPIN; // RQ10
               imm_wait_nxt = 1'b0;
               sp_cnt_nxt = '0;
            end else if (imm_wait_r && sp_cnt_r == 32'(FAIL_CYC - 1)) begin
               start_fail_nxt = 1'b1; // RQ11
               imm_wait_nxt = 1'b0;
               sp_nxt = SP_WAIT_START;
            end
         end
         SP_SPIN: begin
            sp_cnt_nxt = sp_cnt_r + 32'h1;
            if (sp_cnt_r == 32'(READY_CYC - 1)) begin
               sp_nxt = SP_READY; // RQ9
            end
         end
         SP_READY: begin
            if (cmd_wr && c_start_unit && !c_start) begin
               sp_nxt = SP_STOPPING;
               stop_done_nxt = 1'b0;
            end
         end
         SP_STOPPING: begin
            if (stopped_lvl) begin
               sp_nxt = SP_WAIT_START;
               stop_done_nxt = 1'b1; // RQ12
            end
         end
         default: begin
            sp_nxt = SP_IDLE;
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_r <= SP_IDLE; // RQ25
         sp_cnt_r <= '0;
         start_fail_r <= 1'b0;
         imm_wait_r <= 1'b0;
         stop_done_r <= 1'b0;
      end else begin
         sp_r <= sp_nxt;
         sp_cnt_r <= sp_cnt_nxt;
         start_fail_r <= start_fail_nxt;
         imm_wait_r <= imm_wait_nxt;
         stop_done_r <= stop_done_nxt;
      end
   end
   assign spindle_on = (sp_r == SP_SPIN) || (sp_r == SP_READY);

   // ****************************************
   // Cache control and lookup
   // ****************************************
   logic read_cache_disable, disable_read_ahead, check_bit_a;
   logic [2:0] cache_r, cache_nxt;
   logic seg_err_r, seg_err_nxt;
   assign read_cache_disable = cache_r[0];
   assign disable_read_ahead = cache_r[1];
   assign check_bit_a = cache_r[2];
   logic [LBA_W-1:0] rd_lba;
   logic [LEN_W-1:0] rd_len;
   logic rd_go, hit_any;
   logic [SEGS-1:0] hits;
   logic [$clog2(SEGS+1)-1:0] victim_r, victim_nxt;
   logic medium_r, medium_nxt, bufx_r, bufx_nxt;
   assign rd_go = wr && paddr == `OFF_READ && accept_r && sp_r == SP_READY;
   assign rd_lba = LBA_W'(pwdata[31:LEN_W]);
   assign rd_len = pwdata[LEN_W-1:0];
   assign hit_any = |hits;

   for (genvar g = 0; g < SEGS; g++) begin : g_seg
      seg_tag #(.LBA_W(LBA_W), .LEN_W(LEN_W)) u_tag (
         .pclk(pclk),
         .presetn(presetn),
         .load(rd_go && !hit_any && !read_cache_disable && victim_r == g), // RQ17 RQ18
         .drop(wr && paddr == `OFF_SEG && pwdata[g]), // RQ18
         .load_lba(rd_lba),
         .load_len(rd_len),
         .q_lba(rd_lba),
         .q_len(rd_len),
         .hit(hits[g]) // RQ13
      );
   end

   always_comb begin
      cache_nxt = cache_r;
      seg_err_nxt = seg_err_r;
      victim_nxt = victim_r;
      medium_nxt = 1'b0;
      bufx_nxt = 1'b0;
      if (wr && paddr == `OFF_CACHE) begin
         cache_nxt = pwdata[2:0]; // RQ22 RQ23 RQ24
         // Segment-size bits never change the segment setup
         if (pwdata[31:16] != `SEG_SIZE_REPORT && pwdata[2]) begin
            seg_err_nxt = 1'b1; // RQ21
         end
      end
      if (rd_go) begin
         if (!read_cache_disable && hit_any) begin
            bufx_nxt = 1'b1; // RQ14 RQ16
         end else begin
            medium_nxt = 1'b1; // RQ15 RQ17
            bufx_nxt = 1'b1;
            if (!read_cache_disable) begin
               victim_nxt = (32'(victim_r) == SEGS - 1) ? '0 : victim_r + 1'b1;
            end
         end
      end
      if (rd && paddr == `OFF_CACHE) begin
         seg_err_nxt = 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cache_r <= '0;
         seg_err_r <= 1'b0;
         victim_r <= '0;
         medium_r <= 1'b0;
         bufx_r <= 1'b0;
      end else begin
         cache_r <= cache_nxt;
         seg_err_r <= seg_err_nxt;
         victim_r <= victim_nxt;
         medium_r <= medium_nxt;
         bufx_r <= bufx_nxt;
      end
   end
   assign medium_read = medium_r;
   assign buffer_xfer = bufx_r;

   // ****************************************
   // Read mux
   // ****************************************
   logic [31:0] rdata;
   logic bad_addr;
   always_comb begin
      rdata = '0;
      bad_addr = 1'b0;
      case (paddr)
         `OFF_CTRL: rdata = {31'h0, accept_r};
         `OFF_CMD: rdata = '0;
         `OFF_STATUS: rdata = {22'h0, stop_done_r, start_fail_r, sp_r, quick_r,
                               fmt_busy_r, pend_r[0], mode_r[0], check_r};
         `OFF_CACHE: rdata = {`SEG_SIZE_REPORT, 12'h0, seg_err_r, cache_r}; // RQ19 RQ20
         `OFF_READ: rdata = {31'h0, medium_r};
         `OFF_SENSE: rdata = {8'h0, field_ptr_r, sense_key_r, sense_code_r};
         `OFF_SEG: rdata = 32'(hits);
         default: bad_addr = 1'b1;
      endcase
   end
   assign prdata = rd ? rdata : 32'h0;
   assign pslverr = psel & penable & bad_addr;
endmodule : drive_ctrl
`default_nettype wire

// [core/drive_ctrl_map.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: APB byte addressing, 32-bit words
// Notes: Times in their own units; cycle counts derived at 100 MHz
`ifndef DRIVE_CTRL_MAP_SVH
`define DRIVE_CTRL_MAP_SVH

`define CLK_HZ 100000000
`define CMD_ACCEPT_MS 3000
`define READY_WAIT_MS 30000
`define SPINUP_FAIL_MS 5000
`define MS_TO_CYC(ms) ((ms) * (`CLK_HZ / 1000))

`define OFF_CTRL 12'h000
`define OFF_CMD 12'h004
`define OFF_STATUS 12'h008
`define OFF_CACHE 12'h00c
`define OFF_READ 12'h010
`define OFF_SENSE 12'h014
`define OFF_SEG 12'h018

`define FF_QUICK 2'h1
`define SENSE_KEY_ILLEGAL 8'h05
`define SENSE_CODE_INVALID 8'h24
`define SEG_SIZE_REPORT 16'hffff
`define SECTOR_RATIO 8

`endif

// [core/drive_ctrl_pkg.sv]
// Purpose: Types shared by the drive control block
// Assumes: None
// Notes: States use Gray codes along the usual path
package drive_ctrl_pkg;
   typedef enum logic [2:0] {
      SP_IDLE = 3'b000,
      SP_WAIT_START = 3'b001,
      SP_WAIT_EN = 3'b011,
      SP_SPIN = 3'b010,
      SP_READY = 3'b110,
      SP_STOPPING = 3'b111
   } spin_state_e;
   typedef enum logic [1:0] {
      MODE_EMU_SMALL = 2'h0,
      MODE_NATIVE_LARGE = 2'h1
   } sector_mode_e;
endpackage : drive_ctrl_pkg

// [core/seg_tag.sv]
// Purpose: One cache segment tag: LBA range held by a ring segment
// Assumes: Same clock as the parent
// Notes: Ring length is whole blocks
`timescale 1ns/1ps
`default_nettype none
module seg_tag #(
   parameter int LBA_W = 32,
   parameter int LEN_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic drop,
   input wire logic [LBA_W-1:0] load_lba,
   input wire logic [LEN_W-1:0] load_len,
   input wire logic [LBA_W-1:0] q_lba,
   input wire logic [LEN_W-1:0] q_len,
   output logic hit
);
   logic valid_r, valid_nxt;
   logic [LBA_W-1:0] base_r, base_nxt;
   logic [LEN_W-1:0] len_r, len_nxt;
   logic [LBA_W:0] q_end, s_end;

   // Record held address range
   always_comb begin
      valid_nxt = valid_r;
      base_nxt = base_r;
      len_nxt = len_r;
      if (drop) begin
         valid_nxt = 1'b0;
      end
      if (load) begin
         valid_nxt = 1'b1;
         base_nxt = load_lba;
         len_nxt = load_len;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_r <= 1'b0;
         base_r <= '0;
         len_r <= '0;
      end else begin
         valid_r <= valid_nxt;
         base_r <= base_nxt;
         len_r <= len_nxt;
      end
   end

   // Whole request inside the held range
   always_comb begin
      q_end = {1'b0, q_lba} + {{(LBA_W+1-LEN_W){1'b0}}, q_len};
      s_end = {1'b0, base_r} + {{(LBA_W+1-LEN_W){1'b0}}, len_r};
      hit = valid_r && (q_len != '0) && (q_lba >= base_r) && (q_end <= s_end);
   end
endmodule : seg_tag
`default_nettype wire

// [dv/drive_ctrl_properties.sv]
// Purpose: Port assertions for drive_ctrl
// Assumes: One clock, async active-low reset
// Notes: Bound to every drive_ctrl instance
`timescale 1ns/1ps
`default_nettype none
`include "drive_ctrl_map.svh"
module drive_ctrl_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic enable_spinup_a,
   input wire logic enable_spinup_b,
   input wire logic spindle_on,
   input wire logic medium_read,
   input wire logic buffer_xfer
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_acc;
   assign rd_acc = psel && penable && !pwrite;
   AST_PREADY: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   AST_SLVERR: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   AST_RDATA_IDLE: assert property (!rd_acc |-> prdata == 32'h0)
      else $error("prdata not zero outside read");
   AST_MAPPED_OK: assert property (rd_acc && paddr == `OFF_STATUS |-> !pslverr)
      else $error("error on mapped address");
   AST_SEG_SIZE: assert property (rd_acc && paddr == `OFF_CACHE |-> prdata[31:16] == 16'hffff)
      else $error("segment size not all ones");
   AST_SPIN_CAUSE: assert property ($rose(spindle_on) |-> enable_spinup_a || enable_spinup_b)
      else $error("spindle started without notify");
   AST_SPIN_RESET: assert property ($rose(presetn) |-> !spindle_on)
      else $error("spindle on after reset");
   AST_MED_PULSE: assert property (medium_read |=> !medium_read)
      else $error("medium_read longer than one cycle");
   AST_XFER_PULSE: assert property (buffer_xfer |=> !buffer_xfer)
      else $error("buffer_xfer longer than one cycle");
   AST_MED_CAUSE: assert property (medium_read |-> $past(psel && penable && pwrite && paddr == `OFF_READ))
      else $error("medium read without request");
endmodule : drive_ctrl_props
bind drive_ctrl drive_ctrl_props chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .enable_spinup_a(enable_spinup_a), .enable_spinup_b(enable_spinup_b),
   .spindle_on(spindle_on), .medium_read(medium_read), .buffer_xfer(buffer_xfer));
`default_nettype wire

// [dv/drive_ctrl_tb_top.sv]
// Purpose: Self-checking bench for drive_ctrl
// Assumes: APB master tasks, shortened counts
// Notes: Far-side notify pins stay high until reset
`timescale 1ns/1ps
`default_nettype none
`include "drive_ctrl_map.svh"
module drive_ctrl_tb_top;
   localparam int RDY = 50;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic ena, enb, fdone, sstop, spin, mrd, bxf, fmt_go;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] notify_req;
   int mismatches, n_checks, n_med, n_xfer, cyc, t0;
   drive_ctrl #(.ACCEPT_CYC(20), .READY_CYC(RDY), .FAIL_CYC(30)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .enable_spinup_a(ena), .enable_spinup_b(enb), .format_done(fdone),
      .spindle_stopped(sstop), .spindle_on(spin), .medium_read(mrd), .buffer_xfer(bxf));
   drive_link_model far (.pclk(pclk), .presetn(presetn), .notify_req(notify_req),
      .spindle_on(spin), .enable_spinup_a(ena), .enable_spinup_b(enb),
      .format_go(fmt_go), .format_done(fdone), .spindle_stopped(sstop));
   // ***************
   // Clock and monitors
   // ***************
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (mrd === 1'b1) n_med++;
      if (bxf === 1'b1) n_xfer++;
   end
   // ***************
   // Tasks
   // ***************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         mismatches++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic do_read(input logic [31:0] word, input int exp_med, input logic exp_x);
      n_med = 0;
      n_xfer = 0;
      apb(1'b1, `OFF_READ, word);
      repeat (20) @(posedge pclk);
      check(n_med, exp_med);
      check({31'h0, n_xfer != 0}, {31'h0, exp_x});
   endtask : do_read
   task automatic poll(input logic [31:0] mask, input logic [31:0] want);
      for (int i = 0; i < 40; i++) begin
         apb(1'b0, `OFF_STATUS, 32'h0);
         if ((rd & mask) === want) break;
      end
   endtask : poll
   // ***************
   // Main sequence
   // ***************
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      notify_req = 2'h0;
      fmt_go = 1'b0;
      {mismatches, n_checks, cyc} = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFF_CTRL, 32'h0);
      check(rd & 32'h1, 32'h0);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rd & 32'he6, 32'h0);
      check({31'h0, spin}, 32'h0);
      repeat (25) @(posedge pclk);
      apb(1'b0, `OFF_CTRL, 32'h0);
      check(rd & 32'h1, 32'h1);
      $display("test reset done");
      apb(1'b1, `OFF_CACHE, 32'h12340000);
      apb(1'b0, `OFF_CACHE, 32'h0);
      check(rd & 32'hffff000c, 32'hffff0000);
      apb(1'b1, `OFF_CACHE, 32'h12340004);
      apb(1'b0, `OFF_CACHE, 32'h0);
      check(rd & 32'hffff000c, 32'hffff000c);
      apb(1'b0, `OFF_CACHE, 32'h0);
      check(rd & 32'hffff000c, 32'hffff0004);
      apb(1'b1, `OFF_CACHE, 32'h1);
      apb(1'b0, `OFF_CACHE, 32'h0);
      check(rd & 32'h3, 32'h1);
      apb(1'b1, `OFF_CACHE, 32'h2);
      apb(1'b0, `OFF_CACHE, 32'h0);
      check(rd & 32'h3, 32'h2);
      apb(1'b0, 12'h01c, 32'h0);
      check({31'h0, err}, 32'h1);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check({31'h0, err}, 32'h0);
      $display("test registers done");
      apb(1'b1, `OFF_CMD, 32'h700);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rd & 32'h6, 32'h4);
      apb(1'b1, `OFF_CMD, 32'h5c);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rd & 32'h1e, 32'h1c);
      fmt_go <= 1'b1;
      poll(32'he, 32'h6);
      check(rd & 32'he, 32'h6);
      fmt_go <= 1'b0;
      apb(1'b1, `OFF_CMD, 32'h28);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rd & 32'h9, 32'h1);
      apb(1'b0, `OFF_SENSE, 32'h0);
      check(rd, 32'h00410524);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rd & 32'h1, 32'h0);
      $display("test format done");
      do_read(32'h00010004, 0, 1'b0);
      notify_req <= 2'h2;
      t0 = cyc;
      @(posedge pclk);
      notify_req <= 2'h0;
      for (int i = 0; i < 40; i++) begin
         apb(1'b0, `OFF_STATUS, 32'h0);
         if (rd[7:5] === 3'b110) break;
      end
      check(rd & 32'he0, 32'hc0);
      check({31'h0, (cyc - t0) <= RDY + 15}, 32'h1);
      check({31'h0, spin}, 32'h1);
      $display("test spinup done");
      apb(1'b1, `OFF_CACHE, 32'h0);
      do_read(32'h00010004, 1, 1'b1);
      do_read(32'h00010004, 0, 1'b1);
      apb(1'b1, `OFF_SEG, 32'hf);
      do_read(32'h00010004, 1, 1'b1);
      apb(1'b1, `OFF_CACHE, 32'h1);
      do_read(32'h00010004, 1, 1'b1);
      $display("test reads done");
      apb(1'b1, `OFF_CMD, 32'h1);
      poll(32'h3e0, 32'h220);
      check(rd & 32'h3e0, 32'h220);
      check({31'h0, spin}, 32'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (25) @(posedge pclk);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rd & 32'h3e6, 32'h0);
      apb(1'b1, `OFF_CMD, 32'h1);
      apb(1'b1, `OFF_CMD, 32'h7);
      poll(32'h1e0, 32'h120);
      check(rd & 32'h1e0, 32'h120);
      apb(1'b1, `OFF_CMD, 32'h3);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rd & 32'h1e0, 32'h60);
      notify_req <= 2'h1;
      @(posedge pclk);
      notify_req <= 2'h0;
      poll(32'he0, 32'hc0);
      check(rd & 32'he0, 32'hc0);
      $display("test stop start done");
      conclude();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      conclude();
   end
endmodule : drive_ctrl_tb_top
`default_nettype wire

// [dv/drive_link_model.sv]
// Purpose: Far side: link notify pins and spindle mechanics
// Assumes: Same clock as the block
// Notes: Notify pins hold high once sent, until reset
`timescale 1ns/1ps
`default_nettype none
module drive_link_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] notify_req,
   input wire logic spindle_on,
   input wire logic format_go,
   output logic enable_spinup_a,
   output logic enable_spinup_b,
   output logic format_done,
   output logic spindle_stopped
);
   logic [2:0] stop_cnt_r;
   assign spindle_stopped = (stop_cnt_r == 3'h7);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_spinup_a <= 1'b0;
         enable_spinup_b <= 1'b0;
         format_done <= 1'b0;
         stop_cnt_r <= 3'h7;
      end else begin
         // Medium reports the format finished one cycle after the go
         format_done <= format_go;
         if (notify_req[0]) enable_spinup_a <= 1'b1;
         if (notify_req[1]) enable_spinup_b <= 1'b1;
         // Spindle runs down over several cycles
         if (spindle_on) stop_cnt_r <= 3'h0;
         else if (stop_cnt_r != 3'h7) stop_cnt_r <= stop_cnt_r + 3'h1;
      end
   end
endmodule : drive_link_model
`default_nettype wire
